//--- clk_sync_cfg_pkg.sv
// package: offsets, field layout, reset values and timing of the clock delay and sync configuration registers
package clk_sync_cfg_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register indices
  localparam logic [3:0] ADDR_COARSE = 4'hc;
  localparam logic [3:0] ADDR_FINE = 4'hd;
  localparam logic [3:0] ADDR_SYNC = 4'he;
  // reset values
  localparam logic [15:0] RESET_COARSE = 16'h0004;
  localparam logic [15:0] RESET_FINE = 16'h0000;
  localparam logic [15:0] RESET_SYNC = 16'h0003;
  // writable bit masks, reserved bits read as zero
  localparam logic [15:0] MASK_COARSE = 16'hfffc;
  localparam logic [15:0] MASK_FINE = 16'hfdff;
  localparam logic [15:0] MASK_SYNC = 16'hffdf;
  // coarse register fields
  localparam int COARSE_CODE_LSB = 4;
  localparam int COARSE_CODE_W = 12;
  localparam int DELAY_ADJUST_BIT = 3;
  localparam int DUTY_CYCLE_BIT = 2;
  // fine register fields
  localparam int FINE_CODE_LSB = 10;
  localparam int FINE_CODE_W = 6;
  localparam int FILTER_SELECT_BIT = 8;
  localparam int TANK_LSB = 0;
  localparam int TANK_W = 8;
  // sync register fields
  localparam int REF_DELAY_LSB = 6;
  localparam int REF_DELAY_W = 10;
  localparam int PHASE_LSB = 3;
  localparam int PHASE_W = 2;
  localparam int SLAVE_BIT = 2;
  localparam int REFCLK_OFF_BIT = 1;
  localparam int RESET_IN_OFF_BIT = 0;
  // saturation limits
  localparam logic [11:0] COARSE_MAX = 12'h97f;
  localparam logic [9:0] REF_DELAY_MAX = 10'h27f;
  // reference output divide
  localparam int REFCLK_DIV = 4;
  typedef enum logic [1:0] {
    PHASE_0 = 2'b00,
    PHASE_90 = 2'b01,
    PHASE_180 = 2'b10,
    PHASE_270 = 2'b11
  } ref_phase_t;
endpackage

//--- quarter_rate_divider.sv
// divide-by-four clock copy generator for the reference clock outputs
`timescale 1ns/100ps
`default_nettype none
module quarter_rate_divider (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // control
  input wire logic run,
  // output
  output logic div_out
);
  import clk_sync_cfg_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic q;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;

  if (REFCLK_DIV != 4) begin : g_ratio_check
    $error("divider only serves a ratio of four");
  end

  always_comb begin
    state_next = state_reg;
    if (run) begin
      state_next.cnt = state_reg.cnt + 2'h1;
      state_next.q = state_reg.cnt[1];
    end else begin
      state_next.cnt = 2'h0;
      state_next.q = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign div_out = state_reg.q;
endmodule // quarter_rate_divider
`default_nettype wire

//--- clock_delay_sync_config_regs.sv
// clock delay, lc filter and multi-chip sync configuration register bank
`timescale 1ns/100ps
`default_nettype none

module clock_delay_sync_config_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic [clk_sync_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [clk_sync_cfg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [clk_sync_cfg_pkg::DATA_W-1:0] reg_rdata,
  // aperture delay controls
  output logic delay_path_enable,
  output logic [clk_sync_cfg_pkg::COARSE_CODE_W-1:0] coarse_delay_applied,
  output logic [clk_sync_cfg_pkg::FINE_CODE_W-1:0] fine_delay_applied,
  output logic duty_cycle_stabiliser_on,
  // lc filter controls
  output logic lc_filter_enable,
  output logic [clk_sync_cfg_pkg::TANK_W-1:0] tank_frequency_select,
  output logic tank_code_valid,
  // sync controls
  output logic [clk_sync_cfg_pkg::REF_DELAY_W-1:0] reference_delay_applied,
  output clk_sync_cfg_pkg::ref_phase_t reference_phase_select,
  output logic slave_enable,
  input wire logic sync_reference_input,
  output logic sync_reference_latched,
  // reference clock outputs, enables active low
  output logic sync_reference_out_one,
  output logic sync_reference_out_one_oe_n,
  output logic sync_reference_out_two,
  output logic sync_reference_out_two_oe_n,
  // output clock reset
  input wire logic output_clock_reset_input,
  output logic output_clock_reset
);
  import clk_sync_cfg_pkg::*;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] coarse;
    logic [15:0] fine;
    logic [15:0] sync;
    logic [15:0] rdata;
    logic ref_latched;
    logic ref_prev;
    logic clk_rst;
    logic [1:0] phase_cnt;
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;

  logic divided;
  logic refclk_run;
  logic adjust_sel;
  logic filter_sel;

  if (DATA_W != 16 || ADDR_W != 4) begin : g_width_check
    $error("register bank serves only 16-bit data and 4-bit addresses");
  end

  // --------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------
  function automatic logic [15:0] read_mux(input logic [3:0] addr, input bank_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    case (addr)
      ADDR_COARSE: v = s.coarse;
      ADDR_FINE: v = s.fine;
      ADDR_SYNC: v = s.sync;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  function automatic logic is_thermometer(input logic [7:0] code);
    logic ok;
    ok = 1'b1;
    for (int i = 1; i < 8; i++) begin
      if (code[i] && !code[i-1]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // --------------------------------------------------------------------
  // register write and read
  // --------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 16'h0000;
    if (reg_write) begin
      case (reg_addr)
        ADDR_COARSE: state_next.coarse = reg_wdata & MASK_COARSE;
        ADDR_FINE: state_next.fine = reg_wdata & MASK_FINE;
        ADDR_SYNC: state_next.sync = reg_wdata & MASK_SYNC;
        default: state_next.coarse = state_reg.coarse;
      endcase
    end
    if (reg_read) begin
      state_next.rdata = read_mux(reg_addr, state_reg);
    end
    // reference phase counter and latch at the chosen quarter
    state_next.ref_prev = sync_reference_input;
    state_next.phase_cnt = state_reg.phase_cnt + 2'h1;
    if (state_reg.phase_cnt == state_reg.sync[PHASE_LSB +: PHASE_W]) begin
      state_next.ref_latched = sync_reference_input;
    end
    // realign on a rising reference edge, seen against the previous input sample
    if (state_reg.sync[SLAVE_BIT] && sync_reference_input && !state_reg.ref_prev) begin
      state_next.phase_cnt = 2'h0;
    end
    state_next.clk_rst = output_clock_reset_input && !state_reg.sync[RESET_IN_OFF_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg.coarse <= RESET_COARSE;
      state_reg.fine <= RESET_FINE;
      state_reg.sync <= RESET_SYNC;
      state_reg.rdata <= 16'h0000;
      state_reg.ref_latched <= 1'b0;
      state_reg.ref_prev <= 1'b0;
      state_reg.clk_rst <= 1'b0;
      state_reg.phase_cnt <= 2'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;

  // --------------------------------------------------------------------
  // aperture delay and filter controls
  // --------------------------------------------------------------------
  assign adjust_sel = state_reg.coarse[DELAY_ADJUST_BIT];
  assign filter_sel = state_reg.fine[FILTER_SELECT_BIT];
  assign delay_path_enable = filter_sel | adjust_sel;

  always_comb begin
    coarse_delay_applied = '0;
    fine_delay_applied = '0;
    if (delay_path_enable) begin
      if (state_reg.coarse[COARSE_CODE_LSB +: COARSE_CODE_W] > COARSE_MAX) begin
        coarse_delay_applied = COARSE_MAX;
      end else begin
        coarse_delay_applied = state_reg.coarse[COARSE_CODE_LSB +: COARSE_CODE_W];
      end
      fine_delay_applied = state_reg.fine[FINE_CODE_LSB +: FINE_CODE_W];
    end
  end

  assign duty_cycle_stabiliser_on = state_reg.coarse[DUTY_CYCLE_BIT];
  assign lc_filter_enable = filter_sel;
  assign tank_frequency_select = state_reg.fine[TANK_LSB +: TANK_W];
  assign tank_code_valid = is_thermometer(state_reg.fine[TANK_LSB +: TANK_W]);

  // --------------------------------------------------------------------
  // sync controls
  // --------------------------------------------------------------------
  always_comb begin
    if (state_reg.sync[REF_DELAY_LSB +: REF_DELAY_W] >= REF_DELAY_MAX) begin
      reference_delay_applied = REF_DELAY_MAX;
    end else begin
      reference_delay_applied = state_reg.sync[REF_DELAY_LSB +: REF_DELAY_W];
    end
  end

  assign reference_phase_select = ref_phase_t'(state_reg.sync[PHASE_LSB +: PHASE_W]);
  assign slave_enable = state_reg.sync[SLAVE_BIT];
  assign sync_reference_latched = state_reg.ref_latched;
  assign output_clock_reset = state_reg.clk_rst;

  // --------------------------------------------------------------------
  // quarter-rate reference outputs
  // --------------------------------------------------------------------
  assign refclk_run = !state_reg.sync[REFCLK_OFF_BIT];

  quarter_rate_divider u_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(refclk_run),
    .div_out(divided)
  );

  assign sync_reference_out_one = divided;
  assign sync_reference_out_two = divided;
  assign sync_reference_out_one_oe_n = !refclk_run;
  assign sync_reference_out_two_oe_n = !refclk_run;
endmodule // clock_delay_sync_config_regs
`default_nettype wire

//--- ref_master_model.sv
// reference clock source of a master device feeding the sync input
`timescale 1ns/100ps
`default_nettype none
module ref_master_model (
  // clock
  input wire logic clk_sys,
  // control and reference
  input wire logic run,
  output logic ref_out
);
  logic [1:0] cnt_reg;
  // quarter-rate reference as a master sends it, held low while not running
  always_ff @(posedge clk_sys) cnt_reg <= run ? cnt_reg + 2'b01 : 2'b00;
  assign ref_out = cnt_reg[1];
endmodule // ref_master_model
`default_nettype wire

//--- clock_delay_sync_config_regs_checker.sv
// assertions on the ports of the clock delay and sync register bank
`timescale 1ns/100ps
`default_nettype none
module clock_delay_sync_config_regs_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // delay and filter
  input wire logic delay_path_enable,
  input wire logic [clk_sync_cfg_pkg::COARSE_CODE_W-1:0] coarse_delay_applied,
  input wire logic [clk_sync_cfg_pkg::FINE_CODE_W-1:0] fine_delay_applied,
  input wire logic lc_filter_enable,
  input wire logic [clk_sync_cfg_pkg::TANK_W-1:0] tank_frequency_select,
  input wire logic tank_code_valid,
  // sync
  input wire logic [clk_sync_cfg_pkg::REF_DELAY_W-1:0] reference_delay_applied,
  input wire logic sync_reference_out_one,
  input wire logic sync_reference_out_one_oe_n,
  input wire logic sync_reference_out_two,
  input wire logic sync_reference_out_two_oe_n,
  input wire logic output_clock_reset_input,
  input wire logic output_clock_reset
);
  import clk_sync_cfg_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_coarse_cap; coarse_delay_applied <= COARSE_MAX; endproperty
  a_coarse_cap: assert property (p_coarse_cap) else $error("coarse delay above cap");
  property p_path_off; !delay_path_enable |-> coarse_delay_applied == '0 && fine_delay_applied == '0; endproperty
  a_path_off: assert property (p_path_off) else $error("delay codes pass while path off");
  property p_filter_path; lc_filter_enable |-> delay_path_enable; endproperty
  a_filter_path: assert property (p_filter_path) else $error("filter select without delay path");
  property p_tank; tank_code_valid == ((tank_frequency_select & (tank_frequency_select + 8'h01)) == 8'h00); endproperty
  a_tank: assert property (p_tank) else $error("tank code check wrong");
  property p_ref_cap; reference_delay_applied <= REF_DELAY_MAX; endproperty
  a_ref_cap: assert property (p_ref_cap) else $error("reference delay above cap");
  property p_pair; sync_reference_out_one == sync_reference_out_two && sync_reference_out_one_oe_n == sync_reference_out_two_oe_n; endproperty
  a_pair: assert property (p_pair) else $error("reference outputs differ");
  property p_quarter; (!sync_reference_out_one_oe_n)[*6] |-> sync_reference_out_one != $past(sync_reference_out_one, 2); endproperty
  a_quarter: assert property (p_quarter) else $error("reference output not quarter rate");
  property p_rst_gate; !output_clock_reset_input |=> !output_clock_reset; endproperty
  a_rst_gate: assert property (p_rst_gate) else $error("output clock reset without input");
endmodule // clock_delay_sync_config_regs_checker
bind clock_delay_sync_config_regs clock_delay_sync_config_regs_checker chk (.clk_sys, .reset_n, .delay_path_enable,
  .coarse_delay_applied, .fine_delay_applied, .lc_filter_enable, .tank_frequency_select, .tank_code_valid,
  .reference_delay_applied, .sync_reference_out_one, .sync_reference_out_one_oe_n, .sync_reference_out_two,
  .sync_reference_out_two_oe_n, .output_clock_reset_input, .output_clock_reset);
`default_nettype wire

//--- test_clock_delay_sync_config_regs.sv
// self-checking testbench for the clock delay and sync register bank
`timescale 1ns/100ps
`default_nettype none
module test_clock_delay_sync_config_regs;
  import clk_sync_cfg_pkg::*;
  logic clk_sys, reset_n, wr_s, rd_s, ocr_in, run, ref_in, dpe, dcs, lce, tv, slv, o1, o1n, o2, o2n, ocr, lat;
  // slave latch per phase code against the partner's 0,0,1,1 reference pattern
  logic [3:0] lat_exp = 4'b1001;
  logic [3:0] addr;
  logic [15:0] wd, rdata;
  logic [11:0] cda;
  logic [5:0] fda;
  logic [7:0] tank;
  logic [9:0] rda;
  ref_phase_t ph;
  int error_cnt, checked, n;
  logic [11:0] cc[5] = '{12'h000, 12'h97e, 12'h97f, 12'h980, 12'hfff};
  logic [7:0] tt[5] = '{8'h00, 8'h0f, 8'hff, 8'h05, 8'h80};
  logic [9:0] rr[4] = '{10'h000, 10'h27e, 10'h27f, 10'h3ff};
  clock_delay_sync_config_regs dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(addr), .reg_wdata(wd),
    .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata), .delay_path_enable(dpe), .coarse_delay_applied(cda),
    .fine_delay_applied(fda), .duty_cycle_stabiliser_on(dcs), .lc_filter_enable(lce), .tank_frequency_select(tank),
    .tank_code_valid(tv), .reference_delay_applied(rda), .reference_phase_select(ph), .slave_enable(slv),
    .sync_reference_input(ref_in), .sync_reference_latched(lat), .sync_reference_out_one(o1),
    .sync_reference_out_one_oe_n(o1n), .sync_reference_out_two(o2), .sync_reference_out_two_oe_n(o2n),
    .output_clock_reset_input(ocr_in), .output_clock_reset(ocr));
  ref_master_model partner (.clk_sys(clk_sys), .run(run), .ref_out(ref_in));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys);
    wr_s <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    {reset_n, wr_s, rd_s, ocr_in, run} = 5'h00;
    addr = 4'h0;
    wd = 16'h0000;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    run <= 1'b1;
    rd(4'hc, 16'h0004);
    rd(4'hd, 16'h0000);
    rd(4'he, 16'h0003);
    chk(16'(dcs), 16'h0001);
    chk(16'(o1n), 16'h0001);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    rd(4'hc, 16'h0004);
    $display("reset test done");
    wr(4'hc, 16'hfffc);
    rd(4'hc, 16'hfffc);
    chk(16'(dpe), 16'h0001);
    foreach (cc[i]) begin
      wr(4'hc, {cc[i], 4'h8});
      chk(16'(cda), 16'(cc[i] > COARSE_MAX ? COARSE_MAX : cc[i]));
    end
    chk(16'(dcs), 16'h0000);
    wr(4'hc, 16'h97e0);
    chk(16'(dpe), 16'h0000);
    chk(16'(cda), 16'h0000);
    $display("coarse test done");
    wr(4'hd, 16'hfdff);
    rd(4'hd, 16'hfdff);
    chk(16'(fda), 16'h003f);
    chk({lce, dpe, 2'b00, cda}, 16'hc97e);
    wr(4'hd, 16'hfc00);
    chk(16'(fda), 16'h0000);
    foreach (tt[i]) begin
      wr(4'hd, {8'h01, tt[i]});
      chk({7'h00, tv, tank}, {7'h00, (tt[i] & 8'(tt[i] + 8'h01)) == 8'h00, tt[i]});
    end
    $display("fine and filter test done");
    wr(4'he, 16'hffdf);
    rd(4'he, 16'hffdf);
    chk(16'(slv), 16'h0001);
    foreach (rr[i]) begin
      wr(4'he, {rr[i], 6'h00});
      chk(16'(rda), 16'(rr[i] > REF_DELAY_MAX ? REF_DELAY_MAX : rr[i]));
    end
    for (int i = 0; i < 4; i++) begin
      wr(4'he, 16'(i << 3) | 16'h0004);
      chk(16'(ph), 16'(i));
      repeat (8) @(posedge clk_sys);
      #1 chk(16'(lat), 16'(lat_exp[i]));
    end
    $display("sync test done");
    wr(4'he, 16'h0004);
    chk({o1n, o2n, slv}, 3'b001);
    repeat (4) @(posedge clk_sys);
    n = 0;
    repeat (16) begin
      @(posedge clk_sys);
      #1 if (o1 === 1'b1) n++;
    end
    chk(16'(n), 16'h0008);
    wr(4'he, 16'h0000);
    chk(16'(slv), 16'h0000);
    @(posedge clk_sys);
    ocr_in <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk(16'(ocr), 16'h0001);
    wr(4'he, 16'h0001);
    chk(16'(ocr), 16'h0000);
    @(posedge clk_sys);
    ocr_in <= 1'b0;
    $display("refclk and reset test done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(4'hc, 16'h0004);
    rd(4'he, 16'h0003);
    chk(16'(o1n), 16'h0001);
    $display("mid-run reset test done");
    tally_and_finish;
  end
endmodule // test_clock_delay_sync_config_regs
`default_nettype wire
